// [sce_pkg.sv]
// package of constants and types for the sensor cpu execution block
package sce_pkg;

  // ****************************************
  // opcode layout and operation codes
  // ****************************************
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int ADDR_MSB = 3;
  localparam int ADDR_LSB = 0;
  localparam logic [3:0] OP_INCREMENT = 4'h8;
  localparam logic [3:0] OP_DECREMENT = 4'h9;
  localparam logic [3:0] OP_INVERT = 4'hA;
  localparam logic [3:0] OP_BRANCH_NONNEGATIVE = 4'hB;
  localparam logic [3:0] OP_BRANCH_NONZERO = 4'hC;
  localparam logic [3:0] OP_PORT_READ = 4'hD;
  localparam logic [3:0] OP_PORT_WRITE = 4'hE;
  localparam logic [7:0] OP_MULTIPLY = 8'hF3;

  // ****************************************
  // register addresses and timing
  // ****************************************
  localparam logic [3:0] REG_ACCUM = 4'h1;
  localparam logic [3:0] REG_MULTIPLICAND = 4'h3;
  localparam logic [3:0] REG_MULTIPLIER = 4'h4;
  localparam logic [3:0] REG_INDEX = 4'h5;
  localparam int MULT_CYCLES = 16;
  localparam logic [4:0] MULT_LAST = 5'h0F;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SCE_ST_EXEC = 2'b01,
    SCE_ST_MULT = 2'b10
  } sce_state_e;

  // one write to a cpu port
  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [15:0] data;
  } sce_port_wr_s;

endpackage

// [sce_regfile.sv]
// sixteen-word cpu register file with two write ports and combinational read taps
`timescale 1ns/1ps
module sce_regfile
  import sce_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data,
  output logic [15:0] index_data,
  output logic [15:0] accum_data,
  output logic [15:0] mcand_data,
  output logic [15:0] mplier_data,
  input wire logic we_a,
  input wire logic [3:0] wa_a,
  input wire logic [15:0] wd_a,
  input wire logic we_b,
  input wire logic [3:0] wa_b,
  input wire logic [15:0] wd_b
);

  logic [15:0] mem_reg [16];

  // ****************************************
  // storage; port b wins if both name one word
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        mem_reg[i] <= WORD_RESET;
      end
    end else begin
      if (we_a) begin
        mem_reg[wa_a] <= wd_a;
      end
      if (we_b) begin
        mem_reg[wa_b] <= wd_b;
      end
    end
  end

  // reads are combinational taps; the caller registers what it exports
  assign rd_data = mem_reg[rd_addr];
  assign index_data = mem_reg[REG_INDEX];
  assign accum_data = mem_reg[REG_ACCUM];
  assign mcand_data = mem_reg[REG_MULTIPLICAND];
  assign mplier_data = mem_reg[REG_MULTIPLIER];

endmodule

// [sce_exec.sv]
// execution core for the increment..multiply instruction group
// Overview of operation
// (RQ1) op 8: register plus one, carry dropped, one cycle.
// (RQ2) op 9: register minus one, borrow dropped.
// (RQ3) op A: bitwise complement of the register.
// (RQ4) op B: branch when index bit 15 is zero.
// (RQ5) op C: branch when index register is nonzero.
// (RQ6) taken branch: pc becomes pc plus named register.
// (RQ7) failed branch: pc plus one, one cycle either way.
// (RQ8) op D: port value copied to accumulator, port unchanged.
// (RQ9) op E: accumulator copied to port, accumulator kept.
// (RQ10) multiply only for full byte F3; program encodes register 3.
// (RQ11) multiply over 16 cycles; high word to accumulator, low to multiplier.
// (RQ12) multiplicand left untouched by multiply.
// (RQ13) program clears accumulator before multiply.
// (RQ14) register field selects any of sixteen registers.
// (RQ15) non-branch ops advance pc by one; only destinations change.
// (RQ16) opcode bits 7..4 operation, bits 3..0 address.
// (RQ17) index register is address 5.
// (RQ18) accumulator is address 1.
// (RQ19) multiplicand is register 3, multiplier register 4.
// (RQ20) fetch suspended and pc held during multiply.
// (RQ21) multiply operands are signed two's complement.
`timescale 1ns/1ps
module sce_exec
  import sce_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] opcode,
  input wire logic [15:0] port_rd_data,
  output logic [15:0] pc,
  output logic fetch_en,
  output logic [3:0] port_rd_addr,
  output sce_port_wr_s port_wr,
  output logic busy,
  output logic [15:0] accum_out
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] op_field(input logic [7:0] b);
    return b[OP_MSB:OP_LSB]; // [RQ16]
  endfunction

  function automatic logic [3:0] addr_field(input logic [7:0] b);
    return b[ADDR_MSB:ADDR_LSB]; // [RQ16]
  endfunction

  // ****************************************
  // state and register file
  // ****************************************
  sce_state_e state_reg, state_next;
  logic [15:0] pc_reg, pc_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [31:0] prod_reg, prod_next;
  sce_port_wr_s pw_reg, pw_next;
  logic [15:0] acc_out_reg, acc_out_next;
  logic [15:0] rd_data, index_data, accum_data, mcand_data, mplier_data;
  logic we_a, we_b;
  logic [3:0] wa_a, wa_b;
  logic [15:0] wd_a, wd_b;
  logic [3:0] op, ra;

  assign op = op_field(opcode);
  assign ra = addr_field(opcode);

  sce_regfile u_regs (
    .clock(clock),
    .reset_n(reset_n),
    .rd_addr(ra),
    .rd_data(rd_data),
    .index_data(index_data),
    .accum_data(accum_data),
    .mcand_data(mcand_data),
    .mplier_data(mplier_data),
    .we_a(we_a),
    .wa_a(wa_a),
    .wd_a(wd_a),
    .we_b(we_b),
    .wa_b(wa_b),
    .wd_b(wd_b)
  );

  // ****************************************
  // next-state and datapath
  // ****************************************
  // multiply is iterative shift-add of signed partial products: one bit of the
  // multiplier per cycle keeps the adder at 32 bits instead of a full array
  always_comb begin
    logic signed [31:0] part;
    part = '0;
    state_next = state_reg;
    pc_next = pc_reg;
    cnt_next = cnt_reg;
    prod_next = prod_reg;
    pw_next = '0;
    acc_out_next = accum_data;
    we_a = 1'b0;
    wa_a = ra;
    wd_a = WORD_RESET;
    we_b = 1'b0;
    wa_b = REG_MULTIPLIER; // [RQ19]
    wd_b = WORD_RESET;
    unique case (state_reg)
      SCE_ST_EXEC: begin
        pc_next = pc_reg + PC_STEP; // [RQ15] [RQ7]
        unique case (op)
          OP_INCREMENT: begin
            we_a = 1'b1; // [RQ14]
            wd_a = rd_data + 16'h0001; // [RQ1]
          end
          OP_DECREMENT: begin
            we_a = 1'b1;
            wd_a = rd_data - 16'h0001; // [RQ2]
          end
          OP_INVERT: begin
            we_a = 1'b1;
            wd_a = ~rd_data; // [RQ3]
          end
          OP_BRANCH_NONNEGATIVE: begin
            if (!index_data[15]) begin // [RQ4] [RQ17]
              pc_next = pc_reg + rd_data; // [RQ6]
            end
          end
          OP_BRANCH_NONZERO: begin
            if (index_data != WORD_RESET) begin // [RQ5]
              pc_next = pc_reg + rd_data; // [RQ6]
            end
          end
          OP_PORT_READ: begin
            we_a = 1'b1;
            wa_a = REG_ACCUM; // [RQ18]
            wd_a = port_rd_data; // [RQ8]
            acc_out_next = port_rd_data;
          end
          OP_PORT_WRITE: begin
            pw_next.valid = 1'b1; // [RQ9]
            pw_next.addr = ra;
            pw_next.data = accum_data;
          end
          default: begin
            // other codes belong to the first instruction group
            if (opcode == OP_MULTIPLY) begin // [RQ10]
              pc_next = pc_reg; // [RQ20]
              state_next = SCE_ST_MULT;
              cnt_next = '0;
              prod_next = '0; // accumulator is expected clear [RQ13]
            end
          end
        endcase
      end
      SCE_ST_MULT: begin
        part = mplier_data[cnt_reg[3:0]] ? (32'(signed'(mcand_data)) <<< cnt_reg[3:0]) : 32'sd0; // [RQ21]
        if (cnt_reg == MULT_LAST) begin
          prod_next = prod_reg - 32'(part); // sign bit has negative weight [RQ21]
          we_a = 1'b1;
          wa_a = REG_ACCUM;
          wd_a = prod_next[31:16]; // [RQ11]
          we_b = 1'b1;
          wd_b = prod_next[15:0]; // [RQ11] [RQ12]
          acc_out_next = prod_next[31:16];
          pc_next = pc_reg + PC_STEP; // [RQ20]
          state_next = SCE_ST_EXEC;
        end else begin
          prod_next = prod_reg + 32'(part);
          cnt_next = cnt_reg + 5'h01;
        end
      end
      default: begin
        state_next = SCE_ST_EXEC;
      end
    endcase
  end

  // register everything
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SCE_ST_EXEC;
      pc_reg <= PC_RESET;
      cnt_reg <= '0;
      prod_reg <= '0;
      pw_reg <= '0;
      acc_out_reg <= WORD_RESET;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      cnt_reg <= cnt_next;
      prod_reg <= prod_next;
      pw_reg <= pw_next;
      acc_out_reg <= acc_out_next;
    end
  end

  // fetch enable mirrors exec state, both from flops
  assign pc = pc_reg;
  // one-hot codes: bit 0 is the exec state, bit 1 the multiply state
  assign fetch_en = state_reg[0];
  assign busy = state_reg[1];
  assign port_rd_addr = ra;
  assign port_wr = pw_reg;
  assign accum_out = acc_out_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // pc must hold on the entry edge and on every multiply edge but the last
  a_mult_holds_pc: assert property (((state_reg == SCE_ST_EXEC && opcode == OP_MULTIPLY) || // [RQ20]
      (busy && cnt_reg != MULT_LAST)) |=> $stable(pc_reg)) else $error("pc moved during multiply");
  // sixteen cycles is longer than a repetition may count, so check both ends and the step between
  a_mult_length: assert property ((state_reg == SCE_ST_EXEC && opcode == OP_MULTIPLY) |=> // [RQ11]
      (busy && cnt_reg == 5'h00) ##15 (busy && cnt_reg == MULT_LAST) ##1 !busy)
      else $error("multiply not 16 cycles");
  a_mult_count_step: assert property ((busy && cnt_reg != MULT_LAST) |=> // [RQ11]
      (busy && cnt_reg == $past(cnt_reg) + 5'h01)) else $error("multiply counter skipped");
  a_mult_finish_pc: assert property ((busy && cnt_reg == MULT_LAST) |=> // [RQ20]
      (!busy && pc_reg == $past(pc_reg) + PC_STEP)) else $error("pc not advanced after multiply");
  a_incr_result: assert property ((fetch_en && op == OP_INCREMENT) |=> // [RQ1]
      (u_regs.mem_reg[$past(ra)] == $past(rd_data) + 16'h0001)) else $error("increment result wrong");
  a_bnz_taken: assert property ((fetch_en && op == OP_BRANCH_NONZERO && index_data != 16'h0000) |=> // [RQ5]
      pc_reg == $past(pc_reg) + $past(rd_data)) else $error("nonzero branch wrong");
  a_bpl_fall: assert property ((fetch_en && op == OP_BRANCH_NONNEGATIVE && index_data[15]) |=> // [RQ7]
      pc_reg == $past(pc_reg) + 16'h0001) else $error("failed branch pc wrong");
  a_port_write: assert property ((fetch_en && op == OP_PORT_WRITE) |=> // [RQ9]
      (port_wr.valid && port_wr.data == $past(accum_data) && accum_data == $past(accum_data)))
      else $error("port write wrong");
  a_mcand_kept: assert property ((busy && cnt_reg == MULT_LAST) |=> // [RQ12]
      mcand_data == $past(mcand_data)) else $error("multiplicand changed");
  a_port_read: assert property ((fetch_en && op == OP_PORT_READ) |=> // [RQ8]
      accum_out == $past(port_rd_data)) else $error("port read wrong");

  c_mult_run: cover property (busy && cnt_reg == MULT_LAST);
  c_branch_taken: cover property (fetch_en && op == OP_BRANCH_NONZERO && index_data != 16'h0000);
  c_port_write: cover property (port_wr.valid);
  c_fall_through: cover property (fetch_en && op == OP_BRANCH_NONNEGATIVE && index_data[15]);

endmodule

// [sce_model.sv]
// behavioural program memory and cpu port space facing the execution block
`timescale 1ns/1ps
module sce_model
  import sce_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [15:0] pc,
  input wire logic [3:0] port_rd_addr,
  input wire sce_port_wr_s port_wr,
  output logic [7:0] opcode,
  output logic [15:0] port_rd_data
);
  logic [7:0] prog_mem [256];
  logic [15:0] port_mem [16];

  // ****************************************
  // program memory
  // ****************************************
  // the byte for the new pc is presented at the falling edge, half a cycle before it is taken
  initial begin
    for (int i = 0; i < 256; i++) prog_mem[i] = 8'h00;
    for (int i = 0; i < 16; i++) port_mem[i] = 16'h0000;
    opcode = 8'h00;
    forever begin
      @(negedge clock);
      opcode = prog_mem[pc[7:0]];
    end
  end

  // ****************************************
  // cpu ports
  // ****************************************
  // reading leaves the port alone; only a write pulse changes it
  assign port_rd_data = port_mem[port_rd_addr];
  always @(posedge clock) begin
    if (reset_n && port_wr.valid) port_mem[port_wr.addr] <= port_wr.data;
  end
endmodule

// [tb_top.sv]
// self-checking testbench for the sensor cpu execution block
`timescale 1ns/1ps
module tb_top
  import sce_pkg::*;
;
  logic clock, reset_n, fetch_en, busy;
  logic [7:0] opcode;
  logic [15:0] port_rd_data, pc, accum_out;
  logic [3:0] port_rd_addr;
  sce_port_wr_s port_wr, wr_last;
  int fails, samples_checked, wr_seen, n;

  sce_exec dut (.clock(clock), .reset_n(reset_n), .opcode(opcode), .port_rd_data(port_rd_data), .pc(pc),
    .fetch_en(fetch_en), .port_rd_addr(port_rd_addr), .port_wr(port_wr), .busy(busy), .accum_out(accum_out));
  sce_model model (.clock(clock), .reset_n(reset_n), .pc(pc), .port_rd_addr(port_rd_addr),
    .port_wr(port_wr), .opcode(opcode), .port_rd_data(port_rd_data));

  // ****************************************
  // clock, monitor and shared tasks
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // port write pulses are counted at the falling edge, where they have settled
  always @(negedge clock) begin
    if (port_wr.valid === 1'b1) begin
      wr_seen++;
      wr_last = port_wr;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // reset is reapplied per scenario so each program starts from cleared registers
  task automatic boot(input logic [7:0] prog [$]);
    @(negedge clock);
    reset_n = 1'b0;
    for (int i = 0; i < 256; i++) model.prog_mem[i] = (i < prog.size()) ? prog[i] : 8'h00;
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    wr_seen = 0;
  endtask

  // bounded wait: a wrong branch target shows as a pc mismatch, not a hang
  task automatic run_to(input logic [15:0] target);
    n = 0;
    while (pc !== target && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk("pc", target, pc);
  endtask

  task automatic conclude();
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    repeat (16) @(negedge clock);
    chk("pc", PC_RESET, pc);
    chk("accum", WORD_RESET, accum_out);
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("fetch_en", 16'h0001, {15'h0000, fetch_en});
    chk("port_wr", 16'h0000, {15'h0000, port_wr.valid});
  endtask

  task automatic t_unary();
    boot({8'h8F, 8'h9E, 8'hA7, 8'hA2, 8'h82});
    run_to(16'h0005);
    chk("cycles", 16'd5, n[15:0]);
    chk("r15", 16'h0001, dut.u_regs.mem_reg[15]);
    chk("r14", 16'hFFFF, dut.u_regs.mem_reg[14]);
    chk("r7", 16'hFFFF, dut.u_regs.mem_reg[7]);
    chk("r2", 16'h0000, dut.u_regs.mem_reg[2]);
    chk("r1", 16'h0000, dut.u_regs.mem_reg[1]);
  endtask

  task automatic t_ports();
    model.port_mem[7] = 16'h1234;
    boot({8'hD7, 8'hE9});
    run_to(16'h0002);
    repeat (2) @(negedge clock);
    chk("accum", 16'h1234, accum_out);
    chk("port7", 16'h1234, model.port_mem[7]);
    chk("port9", 16'h1234, model.port_mem[9]);
    chk("wr_addr", 16'h0009, {12'h000, wr_last.addr});
    chk("wr_count", 16'h0001, wr_seen[15:0]);
    chk("r1", 16'h1234, dut.u_regs.mem_reg[1]);
  endtask

  // marker increments at 4 and 8 sit where a wrong branch decision would land
  task automatic t_branch();
    boot({8'h86, 8'h86, 8'hC6, 8'hB6, 8'h8F, 8'hA5, 8'hB6, 8'hC6, 8'h8F});
    run_to(16'h000A);
    chk("cycles", 16'd8, n[15:0]);
    chk("r15", 16'h0000, dut.u_regs.mem_reg[15]);
  endtask

  // -2 times 3 tells signed from unsigned; F2 just before must do nothing
  task automatic t_mult();
    boot({8'hA3, 8'h93, 8'h84, 8'h84, 8'h84, 8'h11, 8'hF2, 8'hF3, 8'h8F});
    run_to(16'h0007);
    @(negedge clock);
    chk("busy", 16'h0001, {15'h0000, busy});
    chk("fetch_en", 16'h0000, {15'h0000, fetch_en});
    run_to(16'h0009);
    // sixteen multiply edges, then one more for the increment at address 8
    chk("cycles", 16'h0011, n[15:0]);
    chk("accum", 16'hFFFF, accum_out);
    chk("r4", 16'hFFFA, dut.u_regs.mem_reg[4]);
    chk("r3", 16'hFFFE, dut.u_regs.mem_reg[3]);
    chk("r15", 16'h0001, dut.u_regs.mem_reg[15]);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    reset_n = 1'b0;
    fails = 0;
    samples_checked = 0;
    wr_seen = 0;
    t_reset();
    t_unary();
    t_ports();
    t_branch();
    t_mult();
    conclude();
  end

  // four short programs need well under two thousand cycles
  initial begin
    #20000;
    fails++;
    conclude();
  end
endmodule
